//--- hdl/fsi_consts.vh
// constants for the fieldbus status indicator block
// assumes a 250 MHz system clock and a 32-bit avalon-mm register port
`ifndef FSI_CONSTS_VH
`define FSI_CONSTS_VH
// register byte offsets
`define FSI_REG_ALIAS      4'h0
`define FSI_REG_BUS_STATE  4'h4
`define FSI_REG_DRIVE_STAT 4'h8
`define FSI_REG_CTRL       4'hc
// bus state register fields
`define FSI_BS_STATE_LSB   0
`define FSI_BS_STATE_MSB   3
`define FSI_BS_CFG_BAD     4
`define FSI_BS_SELF_CHG    5
`define FSI_BS_WDOG        6
`define FSI_BS_HW_FAIL     7
// fieldbus state machine codes
`define FSI_ST_INIT        4'h1
`define FSI_ST_PREOP       4'h2
`define FSI_ST_BOOT        4'h3
`define FSI_ST_SAFEOP      4'h4
`define FSI_ST_OP          4'h8
// reset values
`define FSI_BS_RESET       8'h01
`define FSI_CTRL_RESET     1'b0
// fixed link rate in Mbit/s, readable only
`define FSI_LINK_MBPS      8'h64
// timing: one indicator time slot
`define FSI_CLK_PERIOD_NS  4
`define FSI_SLOT_NS        50000000
// last phase of the single flash cycle, in slots (cycle length minus one)
`define FSI_SF_SLOTS       5'h17
// flash on time, double flash gap end and second flash end, in slots
`define FSI_FL_ON_SLOTS    5'h04
`define FSI_DF_GAP_SLOTS   5'h08
`define FSI_DF_END_SLOTS   5'h0c
`endif

//--- hdl/fsi_status.v
// fieldbus status indicator: node numbering, port/state leds, safe stop gating
// assumes pins are asynchronous to clk; registers reached over avalon-mm slave
//
// What this block does
// - node number = units + 10 * tens + 100 * hundreds switch values
// - each reset loads the node number into the station alias register
// - input-port link led follows input port, output-port led output port
// - link led off unlinked, on when linked idle, flickers with traffic
// - error led off while the port has no error
// - error led blinks when the port configuration is invalid
// - error led single flash after an unrequested state change
// - error led double flash when receive sync manager watchdog expires
// - error led steady on for a controller hardware failure
// - run led: init off, preop blink, safeop single, op on, boot flicker
// - safe stop low disables torque and power stage, refuses motion
// - no power voltage: fault on, code double, current single; stop led follows safe stop only
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "fsi_consts.vh"

module fsi_status #(
    parameter SLOT_CYCLES = `FSI_SLOT_NS / `FSI_CLK_PERIOD_NS
) (
    input  wire        clk,
    input  wire        rst,
    // avalon-mm slave
    input  wire [3:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output reg  [31:0] readdata,
    output reg         waitrequest,
    // pins
    input  wire [3:0]  hundreds_digit_switch,
    input  wire [3:0]  tens_digit_switch,
    input  wire [3:0]  units_digit_switch,
    input  wire        in_port_link,
    input  wire        in_port_act,
    input  wire        out_port_link,
    input  wire        out_port_act,
    input  wire        safe_stop_n,
    input  wire        power_volt_ok,
    // indicators and drive control
    output reg         in_link_led,
    output reg         out_link_led,
    output reg         err_led,
    output reg         run_led,
    output reg         drive_fault_led,
    output reg         fault_code_led,
    output reg         current_state_led,
    output reg         stop_input_led,
    output reg         torque_enable,
    output reg         power_stage_enable
);

    // two-flop synchronisers for every pin
    reg  [17:0] sync_a;
    reg  [17:0] sync_b;
    wire [17:0] pin_raw = {hundreds_digit_switch, tens_digit_switch, units_digit_switch,
                           in_port_link, in_port_act, out_port_link, out_port_act,
                           safe_stop_n, power_volt_ok};
    always @(posedge clk)
    begin
        sync_a <= pin_raw;
        sync_b <= sync_a;
    end
    wire [3:0] sw_hund  = sync_b[17:14];
    wire [3:0] sw_tens  = sync_b[13:10];
    wire [3:0] sw_units = sync_b[9:6];
    wire       in_link  = sync_b[5];
    wire       in_act   = sync_b[4];
    wire       out_link = sync_b[3];
    wire       out_act  = sync_b[2];
    wire       stop_ok  = sync_b[1];
    wire       hv_ok    = sync_b[0];

    // digits above nine are not clamped; the sum is plain arithmetic
    // node number from the rotary switches
    wire [15:0] node_number = {12'h000, sw_units}
                            + ({12'h000, sw_tens} * 16'h000a)
                            + ({12'h000, sw_hund} * 16'h0064);

    // alias load waits for the synchronisers to refill after reset
    reg  [1:0]  load_cnt;
    reg  [15:0] station_alias;
    always @(posedge clk)
    begin
        if (rst)
        begin
            load_cnt      <= 2'h0;
            station_alias <= 16'h0000;
        end
        else if (load_cnt != 2'h3)
        begin
            load_cnt <= load_cnt + 2'h1;
            if (load_cnt == 2'h2)
                station_alias <= node_number;
        end
    end

    // shared timebase: one slot tick, two phase counters
    reg  [23:0] slot_cnt;
    reg         slot_tick;
    reg  [4:0]  ph;      // 32-slot cycle: blink, flicker, double flash
    reg  [4:0]  sf_ph;   // 24-slot cycle: single flash
    // ph wraps by itself at 32 slots; sf_ph is cut back after 24
    always @(posedge clk)
    begin
        if (rst)
        begin
            slot_cnt  <= 24'h000000;
            slot_tick <= 1'b0;
            ph        <= 5'h00;
            sf_ph     <= 5'h00;
        end
        else
        begin
            slot_tick <= 1'b0;
            if (slot_cnt == SLOT_CYCLES[23:0] - 24'h000001)
            begin
                slot_cnt  <= 24'h000000;
                slot_tick <= 1'b1;
                ph        <= ph + 5'h01;
                sf_ph     <= (sf_ph == `FSI_SF_SLOTS) ? 5'h00 : sf_ph + 5'h01;
            end
            else
                slot_cnt <= slot_cnt + 24'h000001;
        end
    end

    // pattern levels: slot = 50 ms, conventional indicator timing
    // every pattern reads the same two counters, so leds sharing a
    // pattern stay in phase with one another
    wire flickering_pattern   = ~ph[0];                                   // 50 on / 50 off
    wire blinking_pattern     = ~ph[2];                                   // 200 on / 200 off
    wire single_flash_pattern = (sf_ph < `FSI_FL_ON_SLOTS);               // 200 on / 1000 off
    wire double_flash_first   = (ph < `FSI_FL_ON_SLOTS);
    wire double_flash_second  = (ph >= `FSI_DF_GAP_SLOTS) && (ph < `FSI_DF_END_SLOTS);
    wire double_flash_pattern = double_flash_first | double_flash_second; // 200/200/200/1000

    // activity stretch so short frames stay visible for a whole slot
    reg in_act_seen;
    reg out_act_seen;
    reg in_act_show;
    reg out_act_show;
    always @(posedge clk)
    begin
        if (rst)
        begin
            in_act_seen  <= 1'b0;
            out_act_seen <= 1'b0;
            in_act_show  <= 1'b0;
            out_act_show <= 1'b0;
        end
        else if (slot_tick)
        begin
            // new activity in the tick cycle is kept, not lost
            in_act_show  <= in_act_seen | in_act;
            out_act_show <= out_act_seen | out_act;
            in_act_seen  <= in_act;
            out_act_seen <= out_act;
        end
        else
        begin
            in_act_seen  <= in_act_seen | in_act;
            out_act_seen <= out_act_seen | out_act;
        end
    end

    // software-written registers
    reg  [7:0]  bus_state;
    reg         motion_req;
    wire [3:0]  sm_state = bus_state[`FSI_BS_STATE_MSB:`FSI_BS_STATE_LSB];
    wire        stat_uv  = ~hv_ok;
    wire        stat_sto = ~stop_ok;
    wire [31:0] drive_stat = {16'h0000, `FSI_LINK_MBPS,
                              3'h0, torque_enable, out_link, in_link, stat_sto, stat_uv};

    // avalon slave: one wait cycle, then answer with waitrequest low
    always @(posedge clk)
    begin
        if (rst)
        begin
            waitrequest <= 1'b1;
            readdata    <= 32'h00000000;
            bus_state   <= `FSI_BS_RESET;
            motion_req  <= `FSI_CTRL_RESET;
        end
        else if ((read || write) && waitrequest)
        begin
            waitrequest <= 1'b0;
            readdata    <= 32'h00000000;
            if (read)
            begin
                case (address)
                    `FSI_REG_ALIAS:      readdata <= {16'h0000, station_alias};
                    `FSI_REG_BUS_STATE:  readdata <= {24'h000000, bus_state};
                    `FSI_REG_DRIVE_STAT: readdata <= drive_stat;
                    `FSI_REG_CTRL:       readdata <= {31'h00000000, motion_req};
                    default:             readdata <= 32'h00000000;
                endcase
            end
            // only byte lane 0 carries register bits; other lanes ignored
            else if (byteenable[0])
            begin
                case (address)
                    `FSI_REG_BUS_STATE: bus_state  <= writedata[7:0];
                    `FSI_REG_CTRL:      motion_req <= writedata[0];
                    default:            ;
                endcase
            end
        end
        else
            waitrequest <= 1'b1;
    end

    // link leds per port
    always @(posedge clk)
    begin
        if (rst)
        begin
            in_link_led  <= 1'b0;
            out_link_led <= 1'b0;
        end
        else
        begin
            in_link_led  <= in_link & (in_act_show ? flickering_pattern : 1'b1);
            out_link_led <= out_link & (out_act_show ? flickering_pattern : 1'b1);
        end
    end

    // error led, worst condition first
    always @(posedge clk)
    begin
        if (rst)
            err_led <= 1'b0;
        else if (bus_state[`FSI_BS_HW_FAIL])
            err_led <= 1'b1;
        else if (bus_state[`FSI_BS_WDOG])
            err_led <= double_flash_pattern;
        else if (bus_state[`FSI_BS_SELF_CHG])
            err_led <= single_flash_pattern;
        else if (bus_state[`FSI_BS_CFG_BAD])
            err_led <= blinking_pattern;
        else
            err_led <= 1'b0;
    end

    // run led from the fieldbus state code
    always @(posedge clk)
    begin
        if (rst)
            run_led <= 1'b0;
        else
        begin
            case (sm_state)
                `FSI_ST_INIT:   run_led <= 1'b0;
                `FSI_ST_PREOP:  run_led <= blinking_pattern;
                `FSI_ST_SAFEOP: run_led <= single_flash_pattern;
                `FSI_ST_OP:     run_led <= 1'b1;
                `FSI_ST_BOOT:   run_led <= flickering_pattern;
                default:        run_led <= 1'b0;
            endcase
        end
    end

    // torque path: safe stop or missing power voltage always win over software
    // a motion request written during a stop is kept but gated, so torque
    // comes back once both inputs are healthy unless software clears it
    always @(posedge clk)
    begin
        if (rst)
        begin
            torque_enable      <= 1'b0;
            power_stage_enable <= 1'b0;
        end
        else
        begin
            torque_enable      <= motion_req & stop_ok & hv_ok;
            power_stage_enable <= motion_req & stop_ok & hv_ok;
        end
    end

    // drive status leds; current led flashes while no current flows
    always @(posedge clk)
    begin
        if (rst)
        begin
            drive_fault_led   <= 1'b0;
            fault_code_led    <= 1'b0;
            current_state_led <= 1'b0;
            stop_input_led    <= 1'b0;
        end
        else
        begin
            drive_fault_led   <= stat_uv;
            fault_code_led    <= stat_uv & double_flash_pattern;
            current_state_led <= torque_enable ? 1'b1 : single_flash_pattern;
            stop_input_led    <= stop_ok;
        end
    end

endmodule

//--- tb/fsi_status_checker.sv
// checker: bus handshake, safe stop gating, supply and link leds
// bound to fsi_status; SLOT_CYCLES is handed on from the instance
`timescale 1ns/1ps
module fsi_status_checker #(
    parameter SLOT_CYCLES = 8
) (
    input wire clk,
    input wire rst,
    input wire read,
    input wire write,
    input wire waitrequest,
    input wire in_port_link,
    input wire in_port_act,
    input wire out_port_link,
    input wire safe_stop_n,
    input wire power_volt_ok,
    input wire in_link_led,
    input wire out_link_led,
    input wire err_led,
    input wire drive_fault_led,
    input wire stop_input_led,
    input wire torque_enable,
    input wire power_stage_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    int idle_cnt;
    // idle link time; activity stretch lasts up to two slots
    always @(posedge clk)
        idle_cnt <= (rst || !in_port_link || in_port_act) ? 0 : idle_cnt + 1;
    property p_ans; (read || write) && waitrequest |=> !waitrequest; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_one; !waitrequest |=> waitrequest; endproperty
    a_one: assert property (p_one) else $error("wait low too long");
    property p_stop; !safe_stop_n [*4] |-> !torque_enable && !power_stage_enable; endproperty
    a_stop: assert property (p_stop) else $error("torque during stop");
    property p_uv; !power_volt_ok [*4] |=> drive_fault_led; endproperty
    a_uv: assert property (p_uv) else $error("no supply fault");
    property p_sled; $fell(safe_stop_n) ##1 !safe_stop_n [*3] |=> !stop_input_led; endproperty
    a_sled: assert property (p_sled) else $error("stop led on");
    property p_off; !in_port_link [*4] |=> !in_link_led; endproperty
    a_off: assert property (p_off) else $error("in led lit unlinked");
    property p_ooff; !out_port_link [*4] |=> !out_link_led; endproperty
    a_ooff: assert property (p_ooff) else $error("out led lit unlinked");
    property p_idle; idle_cnt > 3 * SLOT_CYCLES + 4 |-> in_link_led; endproperty
    a_idle: assert property (p_idle) else $error("idle link led off");
    c_stop: cover property ($fell(torque_enable));
    c_err: cover property ($rose(err_led));
    c_rd: cover property (read && !waitrequest);
endmodule
bind fsi_status fsi_status_checker #(.SLOT_CYCLES(SLOT_CYCLES)) u_chk (.*);

//--- tb/fsi_port_model.sv
// far-side port model: link level and frame activity per mode
// mode 0 unplugged, 1 linked idle, 2 linked with frames
`timescale 1ns/1ps
module fsi_port_model (
    input  wire       clk,
    input  wire [1:0] mode,
    output reg        link,
    output reg        act
);
    initial act = 1'b0;
    // frames on alternate cycles keep activity seen every slot
    always @(posedge clk)
    begin
        link <= (mode != 2'h0);
        act  <= (mode == 2'h2) ? ~act : 1'b0;
    end
endmodule

//--- tb/fsi_status_tb.sv
// bench for fsi_status: avalon master, port models, pattern counting
// counts led on-cycles over 96 slots, a multiple of every pattern period
`timescale 1ns/1ps
`include "fsi_consts.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
 $display("BAD %0t mismatch got %h want %h", $time, a, b); end end
module fsi_status_tb;
    localparam SL = 8;
    logic clk = 0, rst = 1, read = 0, write = 0, stp = 1, pok = 1;
    logic [3:0] address = 0, byteenable = 4'hf, h = 0, t = 0, u = 0;
    logic [31:0] writedata = 0, readdata, q;
    logic [1:0] im = 0, om = 0;
    wire ipl, ipa, opl, opa, waitrequest, te, pse;
    wire [7:0] leds;
    int err_count = 0, check_count = 0, seed = 58, c[8];
    int pc[6] = '{0, 768, 384, 384, 128, 192};
    int rp[5] = '{0, 2, 4, 1, 3};
    int ep[5] = '{0, 2, 4, 5, 1};
    int lp[3] = '{0, 1, 3};
    logic [7:0] bs[5] = '{8'h01, 8'h12, 8'h24, 8'h48, 8'h83};
    always #2 clk = ~clk;
    fsi_port_model pin (.clk(clk), .mode(im), .link(ipl), .act(ipa));
    fsi_port_model pout (.clk(clk), .mode(om), .link(opl), .act(opa));
    fsi_status #(.SLOT_CYCLES(SL)) dut (.clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .hundreds_digit_switch(h), .tens_digit_switch(t),
        .units_digit_switch(u), .in_port_link(ipl), .in_port_act(ipa), .out_port_link(opl),
        .out_port_act(opa), .safe_stop_n(stp), .power_volt_ok(pok), .in_link_led(leds[3]),
        .out_link_led(leds[2]), .err_led(leds[4]), .run_led(leds[5]),
        .drive_fault_led(leds[6]), .fault_code_led(leds[1]), .current_state_led(leds[0]),
        .stop_input_led(leds[7]), .torque_enable(te), .power_stage_enable(pse));
    task test_done;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one avalon access; request held until waitrequest is seen low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do begin @(posedge clk); n++; end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
        begin
            err_count++;
            $display("BAD %0t bus answer timeout", $time);
            test_done;
        end
        q = readdata;
        read <= 0;
        write <= 0;
        @(posedge clk);
    endtask
    // settle past sync and activity stretch, then count
    task measure;
        c = '{default: 0};
        repeat (40) @(posedge clk);
        // an unknown led level spoils the count on purpose
        repeat (96 * SL) begin @(posedge clk);
            foreach (c[i]) c[i] += (leds[i] === 1'b1) ? 1 : (leds[i] === 1'b0) ? 0 : 100000; end
    endtask
    initial begin repeat (60000) @(posedge clk); err_count++; $display("BAD %0t timeout", $time); test_done; end
    initial
    begin
        // each reset reloads the alias; first pass all zero
        for (int r = 0; r < 3; r++)
        begin
            if (r > 0) begin h <= $unsigned($random(seed)) % 10; t <= $unsigned($random(seed)) % 10;
                u <= $unsigned($random(seed)) % 10; end
            rst <= 1;
            repeat (5) @(posedge clk);
            rst <= 0;
            repeat (6) @(posedge clk);
            bus(0, `FSI_REG_ALIAS, 0);
            `CHK(q[15:0], 16'(u + 10 * t + 100 * h))
        end
        bus(1, `FSI_REG_ALIAS, 32'h0000_ffff);
        bus(0, `FSI_REG_ALIAS, 0);
        `CHK(q[15:0], 16'(u + 10 * t + 100 * h))
        bus(0, `FSI_REG_BUS_STATE, 0);
        `CHK(q[7:0], `FSI_BS_RESET)
        bus(0, `FSI_REG_DRIVE_STAT, 0);
        `CHK(q[15:8], `FSI_LINK_MBPS)
        bus(0, 4'h2, 0);
        `CHK(q, 32'h0)
        // write with byte lane 0 disabled must leave the register alone
        byteenable <= 4'he;
        bus(1, `FSI_REG_BUS_STATE, $random(seed) | 32'h80);
        byteenable <= 4'hf;
        bus(0, `FSI_REG_BUS_STATE, 0);
        `CHK(q[7:0], `FSI_BS_RESET)
        $display("registers done");
        for (int i = 0; i < 5; i++)
        begin
            im <= 2'(i % 3);
            om <= 2'((i + 1) % 3);
            bus(1, `FSI_REG_BUS_STATE, {24'h0, bs[i]});
            bus(0, `FSI_REG_BUS_STATE, 0);
            `CHK(q[7:0], bs[i])
            measure;
            `CHK(c[5], pc[rp[i]])
            `CHK(c[4], pc[ep[i]])
            `CHK(c[3], pc[lp[i % 3]])
            `CHK(c[2], pc[lp[(i + 1) % 3]])
            `CHK(c[6], 0)
            `CHK(c[1], 0)
            `CHK(c[0], pc[4])
            `CHK(c[7], pc[1])
        end
        $display("patterns done");
        bus(1, `FSI_REG_CTRL, 32'h1);
        repeat (8) @(posedge clk);
        `CHK({te, pse}, 2'b11)
        measure;
        `CHK(c[0], pc[1])
        stp <= 0;
        repeat (5) @(posedge clk);
        `CHK({te, pse}, 2'b00)
        bus(1, `FSI_REG_CTRL, 32'h1);
        repeat (8) @(posedge clk);
        `CHK(te, 1'b0)
        pok <= 0;
        measure;
        `CHK(c[6], pc[1])
        `CHK(c[1], pc[5])
        `CHK(c[0], pc[4])
        `CHK(c[7], 0)
        bus(0, `FSI_REG_DRIVE_STAT, 0);
        `CHK(q[1:0], 2'b11)
        $display("stop and supply done");
        test_done;
    end
endmodule
